/* include/ccs_pkg.sv */
// constants and types shared by the core-state register block
`default_nettype none
package ccs_pkg;
   // register file shape
   localparam int REG_WIDTH_DEFAULT = 32;
   localparam int REG_WIDTH_NARROW = 32;
   localparam int REG_WIDTH_WIDE = 64;
   localparam int SHADOW_SETS_DEFAULT = 4;
   localparam int SHADOW_SETS_MAX = 16;
   localparam int REG_COUNT = 32;
   localparam int REG_IDX_W = 5;
   localparam int SET_W = 4;
   localparam logic [REG_IDX_W-1:0] ZERO_REG_IDX = 5'h00;

   // bus map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_PC = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // control register fields
   localparam int CTRL_RE_BIT = 0;
   localparam int CTRL_CSS_LSB = 4;
   localparam logic CTRL_RE_RESET = 1'h0;
   localparam logic [SET_W-1:0] CTRL_CSS_RESET = 4'h0;

   // status register fields
   localparam int ST_MEM_BE = 0;
   localparam int ST_ACC_BE = 1;
   localparam int ST_REVERSE = 2;
   localparam int ST_LINK = 3;
   localparam int ST_ISA = 4;
   localparam int ST_FCC = 5;
   localparam int ST_USER = 6;
   localparam int ST_PRIV = 7;

   // instruction flow
   localparam logic ISA_WIDE = 1'h0;
   localparam logic ISA_COMPACT = 1'h1;
   localparam logic [31:0] PC_STEP_COMPACT = 32'h2;
   localparam logic [31:0] PC_STEP_WIDE = 32'h4;

   typedef enum logic [1:0] {
      CCS_BUS_IDLE = 2'b01,
      CCS_BUS_RESP = 2'b10
   } ccs_bus_state_t;
endpackage
`default_nettype wire

/* rtl/ccs_byte_lane.sv */
// registered byte-order reversal of one data word
`default_nettype none
module ccs_byte_lane #(
   parameter int WIDTH = 32
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // data
   input wire logic swap,
   input wire logic [WIDTH-1:0] dataIn,
   output logic [WIDTH-1:0] dataOut
);
   localparam int BYTES = WIDTH / 8;

   if (WIDTH < 8 || (WIDTH % 8) != 0) begin : g_bad_width
      $error("ccs_byte_lane: WIDTH must be a whole number of bytes");
   end

   logic [WIDTH-1:0] reversed;

   always_comb begin
      reversed = '0;
      for (int i = 0; i < BYTES; i++) begin
         reversed[i*8 +: 8] = dataIn[(BYTES-1-i)*8 +: 8];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dataOut <= '0;
      end else begin
         dataOut <= swap ? reversed : dataIn;
      end
   end
endmodule
`default_nettype wire

/* rtl/ccs_core_state.sv */
// architectural core state: banked registers, byte order, link flag, pc, bus slave
`default_nettype none
module ccs_core_state #(
   parameter int REG_WIDTH = ccs_pkg::REG_WIDTH_DEFAULT,
   parameter int SHADOW_SETS = ccs_pkg::SHADOW_SETS_DEFAULT,
   parameter logic [31:0] PC_RESET = 32'h0000_0000
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // strap and processor mode
   input wire logic strapBigEndian,
   input wire logic modeUser,
   input wire logic modeKernel,
   input wire logic modeDebug,
   input wire logic sysCopUsable,
   // general register access
   input wire logic [ccs_pkg::REG_IDX_W-1:0] rdIdxA,
   input wire logic [ccs_pkg::REG_IDX_W-1:0] rdIdxB,
   input wire logic rdSetQual,
   input wire logic [ccs_pkg::SET_W-1:0] rdSetSel,
   output logic [REG_WIDTH-1:0] rdDataA,
   output logic [REG_WIDTH-1:0] rdDataB,
   input wire logic wrEn,
   input wire logic [ccs_pkg::REG_IDX_W-1:0] wrIdx,
   input wire logic wrSetQual,
   input wire logic [ccs_pkg::SET_W-1:0] wrSetSel,
   input wire logic [REG_WIDTH-1:0] wrData,
   // byte order and memory data
   input wire logic [31:0] loadData,
   input wire logic [31:0] storeData,
   output logic [31:0] loadDataOrdered,
   output logic [31:0] storeDataOrdered,
   output logic memoryBigEndian,
   output logic accessBigEndian,
   output logic reverseByteOrder,
   // link reservation
   input wire logic linkedLoad,
   input wire logic storeConditional,
   input wire logic reservationLost,
   input wire logic exceptionReturn,
   output logic linkFlag,
   output logic condStoreDone,
   output logic condStoreOk,
   // instruction flow
   input wire logic instrRetire,
   input wire logic instrCompact,
   input wire logic pcAssign,
   input wire logic [31:0] pcTarget,
   input wire logic isaWrite,
   input wire logic isaValue,
   output logic [31:0] programCounter,
   output logic instructionSetSelect,
   // coprocessor condition
   input wire logic copCondition1,
   output logic fpConditionCode,
   // axi4-lite slave
   input wire logic [ccs_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ccs_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ccs_pkg::*;

   if (REG_WIDTH != REG_WIDTH_NARROW && REG_WIDTH != REG_WIDTH_WIDE) begin : g_bad_width
      $error("ccs_core_state: REG_WIDTH must be 32 or 64");
   end

   logic privileged;
   logic reverseNow;
   logic reverseEnableReg;
   logic [SET_W-1:0] currentShadowSetReg;
   logic [SET_W-1:0] rdSetEff;
   logic [SET_W-1:0] wrSetEff;
   logic [31:0] pcNext;
   logic [31:0] statusWord;

   // bus slave state
   ccs_bus_state_t wrState;
   ccs_bus_state_t rdState;
   logic awHeld;
   logic wHeld;
   logic [ADDR_W-1:0] awAddrReg;
   logic awPrivReg;
   logic [31:0] wDataReg;
   logic [3:0] wStrbReg;
   logic controlWrite;
   logic [1:0] wrRespNext;

   assign privileged = modeKernel | modeDebug | sysCopUsable;
   assign reverseNow = reverseEnableReg & modeUser;

   // set-qualified references only honoured for privileged code; user code keeps its own set
   assign rdSetEff = (rdSetQual && privileged) ? rdSetSel : currentShadowSetReg;
   assign wrSetEff = (wrSetQual && privileged) ? wrSetSel : currentShadowSetReg;

   ccs_reg_bank #(
      .WIDTH(REG_WIDTH),
      .SETS(SHADOW_SETS)
   ) u_bank (
      .core_clk(core_clk),
      .rdSetA(rdSetEff),
      .rdIdxA(rdIdxA),
      .rdSetB(currentShadowSetReg),
      .rdIdxB(rdIdxB),
      .rdDataA(rdDataA),
      .rdDataB(rdDataB),
      .wrEn(wrEn),
      .wrSet(wrSetEff),
      .wrIdx(wrIdx),
      .wrData(wrData)
   );

   ccs_byte_lane #(.WIDTH(32)) u_load_lane (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swap(reverseNow),
      .dataIn(loadData),
      .dataOut(loadDataOrdered)
   );

   ccs_byte_lane #(.WIDTH(32)) u_store_lane (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .swap(reverseNow),
      .dataIn(storeData),
      .dataOut(storeDataOrdered)
   );

   // strap is sampled while reset is held, then frozen
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         memoryBigEndian <= strapBigEndian;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reverseByteOrder <= 1'b0;
         // follows the strap while held, so the xor relation also holds on the first edge out of reset
         accessBigEndian <= strapBigEndian;
      end else begin
         reverseByteOrder <= reverseNow;
         accessBigEndian <= memoryBigEndian ^ reverseNow;
      end
   end

   // control register; only privileged bus writes reach it
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reverseEnableReg <= CTRL_RE_RESET;
         currentShadowSetReg <= CTRL_CSS_RESET;
      end else if (controlWrite) begin
         reverseEnableReg <= wDataReg[CTRL_RE_BIT];
         currentShadowSetReg <= wDataReg[CTRL_CSS_LSB +: SET_W];
      end
   end

   // a new reservation wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         linkFlag <= 1'b0;
      end else if (linkedLoad) begin
         linkFlag <= 1'b1;
      end else if (reservationLost || exceptionReturn) begin
         linkFlag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         condStoreDone <= 1'b0;
         condStoreOk <= 1'b0;
      end else begin
         condStoreDone <= storeConditional;
         condStoreOk <= storeConditional & linkFlag;
      end
   end

   always_comb begin
      if (pcAssign) begin
         pcNext = pcTarget;
      end else if (instrRetire) begin
         pcNext = programCounter + (instrCompact ? PC_STEP_COMPACT : PC_STEP_WIDE);
      end else begin
         pcNext = programCounter;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         programCounter <= PC_RESET;
         instructionSetSelect <= ISA_WIDE;
      end else begin
         programCounter <= pcNext;
         if (isaWrite) begin
            instructionSetSelect <= isaValue;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fpConditionCode <= 1'b0;
      end else begin
         fpConditionCode <= copCondition1;
      end
   end

   // status mixes registered state with the unregistered modeUser and privileged terms, so a read is not purely a past value
   always_comb begin
      statusWord = '0;
      statusWord[ST_MEM_BE] = memoryBigEndian;
      statusWord[ST_ACC_BE] = accessBigEndian;
      statusWord[ST_REVERSE] = reverseByteOrder;
      statusWord[ST_LINK] = linkFlag;
      statusWord[ST_ISA] = instructionSetSelect;
      statusWord[ST_FCC] = fpConditionCode;
      statusWord[ST_USER] = modeUser;
      statusWord[ST_PRIV] = privileged;
   end

   // write address and data channels, taken in either order
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b0;
         awAddrReg <= '0;
         awPrivReg <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         awHeld <= 1'b1;
         awAddrReg <= s_axi_awaddr;
         awPrivReg <= s_axi_awprot[0];
      end else begin
         s_axi_awready <= s_axi_awvalid && !awHeld && wrState == CCS_BUS_IDLE;
         if (wrState == CCS_BUS_IDLE && awHeld && wHeld) begin
            awHeld <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b0;
         wDataReg <= '0;
         wStrbReg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         wHeld <= 1'b1;
         wDataReg <= s_axi_wdata;
         wStrbReg <= s_axi_wstrb;
      end else begin
         s_axi_wready <= s_axi_wvalid && !wHeld && wrState == CCS_BUS_IDLE;
         if (wrState == CCS_BUS_IDLE && awHeld && wHeld) begin
            wHeld <= 1'b0;
         end
      end
   end

   // unprivileged control writes are refused, so user code cannot reach undefined set numbers
   always_comb begin
      controlWrite = 1'b0;
      wrRespNext = RESP_DECERR;
      if (wrState == CCS_BUS_IDLE && awHeld && wHeld) begin
         case (awAddrReg)
            ADDR_CONTROL: begin
               if (awPrivReg) begin
                  controlWrite = wStrbReg[0];
                  wrRespNext = RESP_OKAY;
               end else begin
                  wrRespNext = RESP_SLVERR;
               end
            end
            ADDR_STATUS, ADDR_PC: wrRespNext = RESP_SLVERR;
            default: wrRespNext = RESP_DECERR;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wrState <= CCS_BUS_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         case (wrState)
            CCS_BUS_IDLE: begin
               if (awHeld && wHeld) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wrRespNext;
                  wrState <= CCS_BUS_RESP;
               end
            end
            CCS_BUS_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wrState <= CCS_BUS_IDLE;
               end
            end
            default: begin
               s_axi_bvalid <= 1'b0;
               wrState <= CCS_BUS_IDLE;
            end
         endcase
      end
   end

   // read channel: one-cycle ready pulse, answer on the following edge
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rdState <= CCS_BUS_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         case (rdState)
            CCS_BUS_IDLE: begin
               if (s_axi_arvalid && s_axi_arready) begin
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  rdState <= CCS_BUS_RESP;
                  s_axi_rresp <= RESP_OKAY;
                  s_axi_rdata <= '0;
                  case (s_axi_araddr)
                     ADDR_CONTROL: begin
                        if (s_axi_arprot[0]) begin
                           s_axi_rdata[CTRL_RE_BIT] <= reverseEnableReg;
                           s_axi_rdata[CTRL_CSS_LSB +: SET_W] <= currentShadowSetReg;
                        end else begin
                           s_axi_rresp <= RESP_SLVERR;
                        end
                     end
                     ADDR_STATUS: s_axi_rdata <= statusWord;
                     ADDR_PC: s_axi_rdata <= programCounter;
                     default: s_axi_rresp <= RESP_DECERR;
                  endcase
               end else begin
                  s_axi_arready <= s_axi_arvalid;
               end
            end
            CCS_BUS_RESP: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rdState <= CCS_BUS_IDLE;
               end
            end
            default: begin
               s_axi_arready <= 1'b0;
               s_axi_rvalid <= 1'b0;
               rdState <= CCS_BUS_IDLE;
            end
         endcase
      end
   end

   a_zero_reg_read: assert property (@(posedge core_clk) disable iff (!reset_n)
      rdIdxA == ZERO_REG_IDX |=> rdDataA == '0)
      else $error("register zero read nonzero");

   a_endian_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> $stable(memoryBigEndian))
      else $error("memory byte order changed outside reset");

   a_access_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      accessBigEndian == (memoryBigEndian ^ reverseByteOrder))
      else $error("access byte order not memory order xor reverse");

   a_reverse_user: assert property (@(posedge core_clk) disable iff (!reset_n)
      !modeUser |=> !reverseByteOrder)
      else $error("byte order reversed outside user mode");

   a_link_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      linkedLoad ##1 storeConditional |=> condStoreOk && condStoreDone)
      else $error("conditional store failed after linked load");

   a_link_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      exceptionReturn && !linkedLoad |=> !linkFlag)
      else $error("exception return left reservation set");

   a_fcc_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
      $past(reset_n) |-> fpConditionCode == $past(copCondition1))
      else $error("fp condition zero does not follow coprocessor condition");

   a_pc_compact: assert property (@(posedge core_clk) disable iff (!reset_n)
      instrRetire && !pcAssign && instrCompact |=> programCounter == $past(programCounter) + PC_STEP_COMPACT)
      else $error("pc did not advance by two");

   a_write_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_axi_awvalid && s_axi_wvalid && wrState == CCS_BUS_IDLE && !awHeld && !wHeld |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");

   a_read_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
endmodule
`default_nettype wire

/* rtl/ccs_reg_bank.sv */
// banked general registers with a hard-wired zero register
`default_nettype none
module ccs_reg_bank #(
   parameter int WIDTH = ccs_pkg::REG_WIDTH_DEFAULT,
   parameter int SETS = ccs_pkg::SHADOW_SETS_DEFAULT
) (
   // clock
   input wire logic core_clk,
   // read ports
   input wire logic [ccs_pkg::SET_W-1:0] rdSetA,
   input wire logic [ccs_pkg::REG_IDX_W-1:0] rdIdxA,
   input wire logic [ccs_pkg::SET_W-1:0] rdSetB,
   input wire logic [ccs_pkg::REG_IDX_W-1:0] rdIdxB,
   output logic [WIDTH-1:0] rdDataA,
   output logic [WIDTH-1:0] rdDataB,
   // write port
   input wire logic wrEn,
   input wire logic [ccs_pkg::SET_W-1:0] wrSet,
   input wire logic [ccs_pkg::REG_IDX_W-1:0] wrIdx,
   input wire logic [WIDTH-1:0] wrData
);
   import ccs_pkg::*;
   localparam int SEL_W = $clog2(SETS);

   if (SETS < 2 || SETS > SHADOW_SETS_MAX || (SETS & (SETS - 1)) != 0) begin : g_bad_sets
      $error("ccs_reg_bank: SETS must be a power of two from 2 to 16");
   end

   // set numbers above the implemented count wrap; never an out-of-range access
   logic [WIDTH-1:0] regs [SETS*REG_COUNT];

   always_ff @(posedge core_clk) begin
      if (wrEn && wrIdx != ZERO_REG_IDX) begin
         regs[{wrSet[SEL_W-1:0], wrIdx}] <= wrData;
      end
   end

   // reads see the old value when written in the same cycle
   always_ff @(posedge core_clk) begin
      rdDataA <= (rdIdxA == ZERO_REG_IDX) ? '0 : regs[{rdSetA[SEL_W-1:0], rdIdxA}];
      rdDataB <= (rdIdxB == ZERO_REG_IDX) ? '0 : regs[{rdSetB[SEL_W-1:0], rdIdxB}];
   end
endmodule
`default_nettype wire

/* testbench/ccs_mem_model.sv */
// memory-side partner that answers each load one cycle after the word is offered
`default_nettype none
module ccs_mem_model (
   // clock
   input wire logic core_clk,
   // memory data
   input wire logic [31:0] fillWord,
   output logic [31:0] loadData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial loadData = 32'h0;
   // registered so the block never sees a word change within the cycle it samples
   always @(posedge core_clk) loadData <= fillWord;
endmodule
`default_nettype wire

/* testbench/cpu_core_state_rules_bench.sv */
// self-checking bench for the core-state block
`default_nettype none
module cpu_core_state_rules_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ccs_pkg::*;
   logic core_clk = '0, reset_n = '0, strapBigEndian = 1'h1, modeUser = '0, modeKernel = 1'h1, modeDebug = '0;
   logic sysCopUsable = '0, rdSetQual = '0, wrEn = '0, wrSetQual = '0, linkedLoad = '0, storeConditional = '0;
   logic reservationLost = '0, exceptionReturn = '0, instrRetire = '0, instrCompact = '0, pcAssign = '0;
   logic isaWrite = '0, isaValue = '0, copCondition1 = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
   logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
   logic [4:0] rdIdxA = '0, rdIdxB = '0, wrIdx = '0;
   logic [3:0] rdSetSel = '0, wrSetSel = '0, s_axi_wstrb = 4'hf;
   logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] wrData = '0, storeData = '0, fillWord = '0, pcTarget = '0, s_axi_wdata = '0;
   logic [31:0] loadData, rdDataA, rdDataB, loadDataOrdered, storeDataOrdered, programCounter, s_axi_rdata;
   logic memoryBigEndian, accessBigEndian, reverseByteOrder, linkFlag, condStoreDone, condStoreOk;
   logic instructionSetSelect, fpConditionCode, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   // reference model state
   logic [31:0] regM [16][32];
   logic [31:0] lQ, sQ, tgt, pcM = '0;
   logic cQ, ok, revM = '0, linkM = '0, steady = '0, churn = '0;
   logic [3:0] ops [8] = '{4'h8, 4'h4, 4'h1, 4'h4, 4'h8, 4'h2, 4'h4, 4'h9};
   int seed = 32'hd416, errCount = 0, nCompared = 0, live = 0, i;

   ccs_core_state i_dut (.core_clk, .reset_n, .strapBigEndian, .modeUser, .modeKernel, .modeDebug, .sysCopUsable,
      .rdIdxA, .rdIdxB, .rdSetQual, .rdSetSel, .rdDataA, .rdDataB, .wrEn, .wrIdx, .wrSetQual, .wrSetSel, .wrData,
      .loadData, .storeData, .loadDataOrdered, .storeDataOrdered, .memoryBigEndian, .accessBigEndian,
      .reverseByteOrder, .linkedLoad, .storeConditional, .reservationLost, .exceptionReturn, .linkFlag,
      .condStoreDone, .condStoreOk, .instrRetire, .instrCompact, .pcAssign, .pcTarget, .isaWrite, .isaValue,
      .programCounter, .instructionSetSelect, .copCondition1, .fpConditionCode, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ccs_mem_model i_mem (.core_clk, .fillWord, .loadData);

   initial forever #4 core_clk = ~core_clk;

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      if (errCount == 0 && nCompared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic logic [31:0] sw(input logic [31:0] w);
      return revM ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
   endfunction

   // the leading edge keeps back-to-back calls from assigning a strobe twice in one step
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic p, input logic [1:0] er);
      int t;
      t = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awprot <= {2'h0, p};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         t++;
      end while (!s_axi_bvalid && t < 40);
      s_axi_bready <= 1'h0;
      chk({s_axi_bvalid, s_axi_bresp}, {1'h1, er});
   endtask

   task automatic axr(input logic [7:0] a, input logic p, input logic [1:0] er, input logic [31:0] ed);
      int t;
      t = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arprot <= {2'h0, p};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         t++;
      end while (!s_axi_rvalid && t < 40);
      s_axi_rready <= 1'h0;
      chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'h1, er, ed});
   endtask

   // plain writes land in shadow set 2, which the control register selects below
   task automatic wr(input logic [4:0] x, input logic q, input logic [3:0] s, input logic [31:0] d);
      @(posedge core_clk);
      wrEn <= 1'h1;
      wrIdx <= x;
      wrSetQual <= q;
      wrSetSel <= s;
      wrData <= d;
      regM[q ? s : 4'h2][x] = x ? d : '0;
      @(posedge core_clk);
      wrEn <= 1'h0;
   endtask

   task automatic rd(input logic [4:0] x, input logic q, input logic [3:0] s, input logic [31:0] e);
      @(posedge core_clk);
      rdIdxA <= x;
      rdIdxB <= x;
      rdSetQual <= q;
      rdSetSel <= s;
      repeat (2) @(posedge core_clk);
      chk(rdDataA, e);
      chk(rdDataB, regM[2][x]);
   endtask

   // per-cycle comparison of the registered data paths against the model
   always @(posedge core_clk) begin
      if (live > 2) begin
         chk(fpConditionCode, cQ);
         if (steady) begin
            chk(loadDataOrdered, sw(lQ));
            chk(storeDataOrdered, sw(sQ));
         end
      end
      if (churn) begin
         copCondition1 <= 1'($random(seed));
         fillWord <= $random(seed);
         storeData <= $random(seed);
      end
      cQ = copCondition1;
      lQ = loadData;
      sQ = storeData;
      live = reset_n ? live + 1 : 0;
   end

   initial begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'h1;
      axr(ADDR_STATUS, 1'h1, RESP_OKAY, 32'h83);
      axr(ADDR_CONTROL, 1'h1, RESP_OKAY, 32'h0);
      axw(ADDR_CONTROL, 32'h20, 1'h1, RESP_OKAY);
      for (i = 0; i < 8; i++) wr(5'((i * 9) % 32), 1'h0, 4'h0, $random(seed));
      for (i = 0; i < 8; i++) rd(5'((i * 9) % 32), 1'h0, 4'h0, regM[2][(i * 9) % 32]);
      wr(5'h9, 1'h1, 4'h1, $random(seed));
      rd(5'h9, 1'h1, 4'h1, regM[1][9]);
      modeUser <= 1'h1;
      modeKernel <= 1'h0;
      rd(5'h9, 1'h1, 4'h1, regM[2][9]);
      axw(ADDR_CONTROL, 32'h21, 1'h0, RESP_SLVERR);
      axr(ADDR_CONTROL, 1'h1, RESP_OKAY, 32'h20);
      axw(ADDR_CONTROL, 32'h21, 1'h1, RESP_OKAY);
      churn = 1'h1;
      for (i = 0; i < 4; i++) begin
         steady = 1'h0;
         if (i == 3) axw(ADDR_CONTROL, 32'h20, 1'h1, RESP_OKAY);
         modeUser <= i[0];
         modeKernel <= !i[0];
         revM = i[0] && i < 3;
         repeat (4) @(posedge core_clk);
         steady = 1'h1;
         repeat (8) @(posedge core_clk);
         chk({memoryBigEndian, accessBigEndian, reverseByteOrder}, {1'h1, !revM, revM});
      end
      churn = 1'h0;
      @(posedge core_clk);
      axr(ADDR_STATUS, 1'h0, RESP_OKAY, 32'h43 | {26'h0, copCondition1, 5'h0});
      // coprocessor-usable and debug each grant set-qualified access on their own
      for (i = 1; i < 3; i++) begin
         {modeDebug, sysCopUsable} <= 2'(i);
         rd(5'h9, 1'h1, 4'h1, regM[1][9]);
      end
      {modeDebug, sysCopUsable} <= 2'h0;
      axr(ADDR_CONTROL, 1'h0, RESP_SLVERR, 32'h0);
      axr(8'h0c, 1'h1, RESP_DECERR, 32'h0);
      for (i = 0; i < 8; i++) begin
         @(posedge core_clk);
         {linkedLoad, storeConditional, reservationLost, exceptionReturn} <= ops[i];
         ok = linkM;
         linkM = ops[i][3] | (linkM & ~|ops[i][1:0]);
         @(posedge core_clk);
         {linkedLoad, storeConditional, reservationLost, exceptionReturn} <= 4'h0;
         @(posedge core_clk);
         chk(linkFlag, linkM);
         if (ops[i][2]) chk({condStoreDone, condStoreOk}, {1'h1, ok});
      end
      // conditional store in the cycle right after the linked load
      @(posedge core_clk);
      linkedLoad <= 1'h1;
      @(posedge core_clk);
      {linkedLoad, storeConditional} <= 2'h1;
      @(posedge core_clk);
      storeConditional <= 1'h0;
      @(posedge core_clk);
      chk({condStoreDone, condStoreOk, linkFlag}, 3'h7);
      for (i = 0; i < 6; i++) begin
         @(posedge core_clk);
         tgt = $random(seed);
         {instrRetire, instrCompact, pcAssign, isaWrite, isaValue} <= {1'h1, i[0], i == 4, 1'h1, i[0]};
         pcTarget <= tgt;
         pcM = (i == 4) ? tgt : pcM + (i[0] ? 32'h2 : 32'h4);
         @(posedge core_clk);
         {instrRetire, pcAssign, isaWrite} <= 3'h0;
         @(posedge core_clk);
         chk(programCounter, pcM);
         chk(instructionSetSelect, i[0] ? ISA_COMPACT : ISA_WIDE);
      end
      axr(ADDR_PC, 1'h1, RESP_OKAY, pcM);
      axw(ADDR_PC, 32'h0, 1'h1, RESP_SLVERR);
      @(posedge core_clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      chk({programCounter, linkFlag, reverseByteOrder}, {32'h0, 2'h0});
      reset_n <= 1'h1;
      axr(ADDR_CONTROL, 1'h1, RESP_OKAY, 32'h0);
      summarize();
   end

   // the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      errCount++;
      summarize();
   end
endmodule
`default_nettype wire
